/* rtl/sonet_frame_align_map.svh */
// Constants of the frame aligner and mode decoder.
// Assumes inclusion by bare name from the rtl folder.
`ifndef SONET_FRAME_ALIGN_MAP_SVH
`define SONET_FRAME_ALIGN_MAP_SVH
// ****************************************
// Mode control codes
// ****************************************
`define MODE_RESET 4'h0
`define MODE_TRI_ALL 4'h1
`define MODE_NAND 4'h2
`define MODE_TRI_REF 4'h3
`define MODE_NO_RECOV 4'h4
`define MODE_EQUIP 4'h5
`define MODE_FACIL 4'h6
`define MODE_SPLIT 4'h7
// ****************************************
// Framing and timing counts
// ****************************************
`define FRAME_PAT 48'hF6F6F6282828
`define BYTE_LAST 3'h7
`define BYTE_HALF 3'h4
`define REF_MAX_12 4'hB
`define REF_MAX_3 4'h2
`define REF_HALF_12 4'h6
`define REF_HALF_3 4'h2
`define CFG_RST 3'h3
// ****************************************
// Register map
// ****************************************
`define CTRL_OFS 8'h00
`define STAT_OFS 8'h04
`define CTRL_SOFT_OOF 0
`define STAT_SEARCH 0
`define STAT_CFG 1
`define STAT_MODE 4
`define STAT_BITCNT 8
`endif

/* rtl/sonet_frame_align_mode_ctrl.sv */
// Frame aligner, serializer, deserializer and mode decoder.
// Assumes i_clk is the bit clock model and all inputs are synchronous.
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
`include "sonet_frame_align_map.svh"
module sonet_frame_align_mode_ctrl (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [3:0] i_mode_control_pins,
   input wire logic i_out_of_frame_in,
   input wire logic i_rx_serial_clock,
   input wire logic i_rx_serial_data,
   input wire logic [7:0] i_mux_byte_in,
   input wire logic i_low_speed_ref_clock_in,
   input wire logic i_ext_high_speed_clock_in,
   input wire sonet_frame_align_pkg::apb_req_t i_apb_req,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_tx_serial_clock,
   output logic o_tx_serial_data,
   output logic [2:0] o_mux_byte_clock_out,
   output logic [7:0] o_demux_byte_out,
   output logic o_demux_byte_clock,
   output logic o_frame_sync_pulse,
   output logic o_demux_ref_clock_out,
   output logic o_test_chain_observe_out,
   output logic o_ttl_oe,
   output logic o_ref_clock_oe,
   output logic o_synth_enable,
   output logic o_synth_ref_clock
);
   // ****************************************
   // State
   // ****************************************
   sonet_frame_align_pkg::clk_cfg_t cfg_reg, cfg_next;
   sonet_frame_align_pkg::frame_state_t fr_reg, fr_next;
   sonet_frame_align_pkg::path_t path;
   logic [1:0] div4_reg, div4_next;
   logic [47:0] hist_reg, hist_next;
   logic [2:0] bit_cnt_reg, bit_cnt_next;
   logic [3:0] ref_cnt_reg, ref_cnt_next;
   logic [2:0] tx_cnt_reg, tx_cnt_next;
   logic [7:0] tx_sh_reg, tx_sh_next;
   logic [7:0] byte_reg, byte_next;
   logic tx_d_reg, tx_d_next, oof_prev_reg, oof_prev_next;
   logic sync_reg, sync_next, dclk_reg, dclk_next;
   logic ref_clk_reg, ref_clk_next, mclk_reg, mclk_next;
   logic txo_reg, txo_next, tx_serial_clock_reg, tx_serial_clock_next;
   logic ttl_oe_reg, ttl_oe_next, ref_oe_reg, ref_oe_next;
   logic obs_reg, obs_next, syn_en_reg, syn_en_next;
   logic syn_ref_reg, syn_ref_next, soft_oof_reg, soft_oof_next;
   logic pready_reg, pready_next, slverr_reg, slverr_next;
   logic [31:0] prdata_reg, prdata_next;
   logic rst_mode, bit_en, equip, facil, rx_in, match;
   logic oof_rise, realign, boundary, nand_c, setup, wr;
   logic [3:0] ref_max, ref_half;
   logic [9:0] ttl_in;
   // ****************************************
   // Mode decode, framing, serial paths
   // ****************************************
   always_comb
   begin
      rst_mode = i_mode_control_pins == `MODE_RESET;
      cfg_next = cfg_reg;
      if (i_mode_control_pins[3])
      begin
         cfg_next.bypass = ~i_mode_control_pins[2];
         cfg_next.master = i_mode_control_pins[0];
         cfg_next.rate12 = i_mode_control_pins[1];
      end
      unique case (i_mode_control_pins)
         `MODE_EQUIP: path = sonet_frame_align_pkg::PATH_EQUIP;
         `MODE_FACIL: path = sonet_frame_align_pkg::PATH_FACIL;
         `MODE_SPLIT: path = sonet_frame_align_pkg::PATH_SPLIT;
         default: path = sonet_frame_align_pkg::PATH_NORMAL;
      endcase
      equip = path == sonet_frame_align_pkg::PATH_EQUIP
         || path == sonet_frame_align_pkg::PATH_SPLIT;
      facil = path == sonet_frame_align_pkg::PATH_FACIL
         || path == sonet_frame_align_pkg::PATH_SPLIT;
      bit_en = ~rst_mode & (cfg_reg.rate12 | div4_reg == 2'h0);
      div4_next = rst_mode ? 2'h0 : div4_reg + 2'h1;
      rx_in = equip ? tx_d_reg : i_rx_serial_data;
      hist_next = bit_en ? {hist_reg[46:0], rx_in} : hist_reg;
      match = bit_en & (hist_next == `FRAME_PAT);
      oof_rise = (i_out_of_frame_in & ~oof_prev_reg) | soft_oof_reg;
      oof_prev_next = i_out_of_frame_in;
      fr_next = fr_reg;
      if (rst_mode)
         fr_next = sonet_frame_align_pkg::FR_HOLD;
      else if (oof_rise && i_mode_control_pins != `MODE_NO_RECOV)
         fr_next = sonet_frame_align_pkg::FR_SEARCH;
      else if (match)
         fr_next = sonet_frame_align_pkg::FR_HOLD;
      realign = fr_reg == sonet_frame_align_pkg::FR_SEARCH && match;
      boundary = bit_en & (bit_cnt_reg == `BYTE_LAST | realign);
      if (rst_mode || boundary)
         bit_cnt_next = 3'h0;
      else
         bit_cnt_next = bit_cnt_reg + {2'h0, bit_en};
      byte_next = boundary ? hist_next[7:0] : byte_reg;
      sync_next = boundary ? match : sync_reg;
      dclk_next = bit_cnt_next >= `BYTE_HALF;
      ref_max = cfg_reg.rate12 ? `REF_MAX_12 : `REF_MAX_3;
      ref_half = cfg_reg.rate12 ? `REF_HALF_12 : `REF_HALF_3;
      ref_cnt_next = ref_cnt_reg;
      if (rst_mode || (bit_en && ref_cnt_reg >= ref_max))
         ref_cnt_next = 4'h0;
      else if (bit_en)
         ref_cnt_next = ref_cnt_reg + 4'h1;
      ref_clk_next = ref_cnt_next < ref_half;
      tx_cnt_next = tx_cnt_reg;
      tx_sh_next = tx_sh_reg;
      tx_d_next = tx_d_reg;
      if (rst_mode)
         tx_cnt_next = 3'h0;
      else if (bit_en)
      begin
         tx_cnt_next = tx_cnt_reg + 3'h1;
         if (tx_cnt_reg == `BYTE_LAST)
         begin
            tx_d_next = i_mux_byte_in[7];
            tx_sh_next = {i_mux_byte_in[6:0], 1'b0};
         end
         else
         begin
            tx_d_next = tx_sh_reg[7];
            tx_sh_next = {tx_sh_reg[6:0], 1'b0};
         end
      end
      mclk_next = tx_cnt_next < `BYTE_HALF;
      txo_next = facil ? i_rx_serial_data : tx_d_next;
      if (facil)
         tx_serial_clock_next = i_rx_serial_clock;
      else if (cfg_reg.bypass)
         tx_serial_clock_next = i_ext_high_speed_clock_in;
      else
         tx_serial_clock_next = bit_en;
      ttl_oe_next = i_mode_control_pins != `MODE_TRI_ALL;
      ref_oe_next = i_mode_control_pins != `MODE_TRI_REF;
      ttl_in = {i_mux_byte_in, i_out_of_frame_in, i_low_speed_ref_clock_in};
      nand_c = 1'b1;
      for (int i = 0; i < 10; i++)
         nand_c = ~(nand_c & ttl_in[i]);
      obs_next = (i_mode_control_pins == `MODE_NAND) & nand_c;
      syn_en_next = ~cfg_next.bypass;
      syn_ref_next = cfg_next.master ? i_low_speed_ref_clock_in
         : i_rx_serial_clock;
   end
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         cfg_reg <= `CFG_RST;
         fr_reg <= sonet_frame_align_pkg::FR_HOLD;
         div4_reg <= 2'h0;
         hist_reg <= 48'h0;
         bit_cnt_reg <= 3'h0;
         ref_cnt_reg <= 4'h0;
         tx_cnt_reg <= 3'h0;
         tx_sh_reg <= 8'h0;
         byte_reg <= 8'h0;
         tx_d_reg <= 1'b0;
         oof_prev_reg <= 1'b0;
         sync_reg <= 1'b0;
         dclk_reg <= 1'b0;
         ref_clk_reg <= 1'b0;
         mclk_reg <= 1'b0;
         txo_reg <= 1'b0;
         tx_serial_clock_reg <= 1'b0;
         ttl_oe_reg <= 1'b0;
         ref_oe_reg <= 1'b0;
         obs_reg <= 1'b0;
         syn_en_reg <= 1'b0;
         syn_ref_reg <= 1'b0;
      end
      else
      begin
         cfg_reg <= cfg_next;
         fr_reg <= fr_next;
         div4_reg <= div4_next;
         hist_reg <= hist_next;
         bit_cnt_reg <= bit_cnt_next;
         ref_cnt_reg <= ref_cnt_next;
         tx_cnt_reg <= tx_cnt_next;
         tx_sh_reg <= tx_sh_next;
         byte_reg <= byte_next;
         tx_d_reg <= tx_d_next;
         oof_prev_reg <= oof_prev_next;
         sync_reg <= sync_next;
         dclk_reg <= dclk_next;
         ref_clk_reg <= ref_clk_next;
         mclk_reg <= mclk_next;
         txo_reg <= txo_next;
         tx_serial_clock_reg <= tx_serial_clock_next;
         ttl_oe_reg <= ttl_oe_next;
         ref_oe_reg <= ref_oe_next;
         obs_reg <= obs_next;
         syn_en_reg <= syn_en_next;
         syn_ref_reg <= syn_ref_next;
      end
   end
   // ****************************************
   // APB slave
   // ****************************************
   always_comb
   begin
      setup = i_apb_req.psel & ~i_apb_req.penable;
      wr = i_apb_req.psel & i_apb_req.penable & pready_reg & i_apb_req.pwrite;
      pready_next = setup;
      soft_oof_next = wr & (i_apb_req.paddr == `CTRL_OFS)
         & i_apb_req.pwdata[`CTRL_SOFT_OOF];
      slverr_next = setup & (i_apb_req.paddr != `CTRL_OFS)
         & (i_apb_req.paddr != `STAT_OFS);
      prdata_next = prdata_reg;
      if (setup)
      begin
         prdata_next = 32'h0;
         if (!i_apb_req.pwrite && i_apb_req.paddr == `STAT_OFS)
         begin
            prdata_next[`STAT_SEARCH] = fr_reg == sonet_frame_align_pkg::FR_SEARCH;
            prdata_next[`STAT_CFG +: 3] = cfg_reg;
            prdata_next[`STAT_MODE +: 4] = i_mode_control_pins;
            prdata_next[`STAT_BITCNT +: 3] = bit_cnt_reg;
         end
      end
   end
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         pready_reg <= 1'b0;
         slverr_reg <= 1'b0;
         prdata_reg <= 32'h0;
         soft_oof_reg <= 1'b0;
      end
      else
      begin
         pready_reg <= pready_next;
         slverr_reg <= slverr_next;
         prdata_reg <= prdata_next;
         soft_oof_reg <= soft_oof_next;
      end
   end
   assign o_prdata = prdata_reg;
   assign o_pready = pready_reg;
   assign o_pslverr = slverr_reg;
   assign o_tx_serial_clock = tx_serial_clock_reg;
   assign o_tx_serial_data = txo_reg;
   assign o_mux_byte_clock_out = {3{mclk_reg}};
   assign o_demux_byte_out = byte_reg;
   assign o_demux_byte_clock = dclk_reg;
   assign o_frame_sync_pulse = sync_reg;
   assign o_demux_ref_clock_out = ref_clk_reg;
   assign o_test_chain_observe_out = obs_reg;
   assign o_ttl_oe = ttl_oe_reg;
   assign o_ref_clock_oe = ref_oe_reg;
   assign o_synth_enable = syn_en_reg;
   assign o_synth_ref_clock = syn_ref_reg;
   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);
   chk_sync_hold: assert property (
      o_frame_sync_pulse && !boundary |=> o_frame_sync_pulse)
      else $error("frame sync dropped inside a byte");
   chk_sync_cause: assert property (
      $rose(o_frame_sync_pulse) |-> $past(match))
      else $error("frame sync without pattern");
   chk_search_start: assert property (
      oof_rise && i_mode_control_pins > `MODE_NO_RECOV
      |=> fr_reg == sonet_frame_align_pkg::FR_SEARCH)
      else $error("search not started");
   chk_recov_off: assert property (
      i_mode_control_pins == `MODE_NO_RECOV
      && fr_reg == sonet_frame_align_pkg::FR_HOLD
      |=> fr_reg == sonet_frame_align_pkg::FR_HOLD)
      else $error("search started while disabled");
   chk_realign_byte: assert property (
      realign |=> bit_cnt_reg == 3'h0 && o_frame_sync_pulse && !o_demux_byte_clock)
      else $error("realign failed");
   chk_no_slip: assert property (
      fr_reg == sonet_frame_align_pkg::FR_HOLD && bit_en && !rst_mode
      && bit_cnt_reg != `BYTE_LAST |=> bit_cnt_reg == $past(bit_cnt_reg) + 3'h1)
      else $error("byte boundary moved while aligned");
   chk_cfg_held: assert property (
      !i_mode_control_pins[3] |=> $stable(cfg_reg))
      else $error("clock settings changed");
   chk_loop_clock: assert property (
      i_mode_control_pins == `MODE_FACIL
      |=> o_tx_serial_clock == $past(i_rx_serial_clock))
      else $error("loop clock not routed");
   chk_reset_mode: assert property (
      rst_mode |=> bit_cnt_reg == 3'h0 && tx_cnt_reg == 3'h0
      && fr_reg == sonet_frame_align_pkg::FR_HOLD)
      else $error("reset mode left state active");
   chk_tristate: assert property (
      i_mode_control_pins == `MODE_TRI_ALL |=> !o_ttl_oe && o_ref_clock_oe)
      else $error("wrong tristate");
   cov_search_hit: cover property (realign);
   cov_aligned_sync: cover property (
      $rose(o_frame_sync_pulse) && fr_reg == sonet_frame_align_pkg::FR_HOLD);
   cov_split_loop: cover property (i_mode_control_pins == `MODE_SPLIT && bit_en);
endmodule : sonet_frame_align_mode_ctrl

/* rtl/sonet_frame_align_pkg.sv */
// Types shared by the frame aligner and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package sonet_frame_align_pkg;
   typedef struct packed {
      logic bypass;
      logic master;
      logic rate12;
   } clk_cfg_t;
   typedef enum logic [1:0] {PATH_NORMAL, PATH_EQUIP, PATH_FACIL, PATH_SPLIT} path_t;
   typedef enum logic {FR_HOLD, FR_SEARCH} frame_state_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;
endpackage : sonet_frame_align_pkg

/* tb/overhead_partner.sv */
// Parallel-side partner: offers one transmit byte per mux byte clock.
// Assumes the mux byte clock comes from the device, sampled on i_clk.
`timescale 1ns/1ps
module overhead_partner (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_mux_clk,
   output logic [7:0] o_byte
);
   logic mclk_d;
   int seed = 42453;
   // New byte only after a seen rise, so it stands over the next capture
   always @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         mclk_d <= 1'b0;
         o_byte <= 8'hA5;
      end
      else
      begin
         mclk_d <= i_mux_clk;
         if (i_mux_clk && !mclk_d)
            o_byte <= 8'($random(seed));
      end
   end
endmodule : overhead_partner

/* tb/test_sonet_frame_align_mode_ctrl.sv */
// Bench for the frame aligner and mode decoder.
// Assumes the partner model overhead_partner beside it.
`timescale 1ns/1ps
module test_sonet_frame_align_mode_ctrl;
   logic i_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] pins = 4'hF;
   logic out_of_frame_in = 1'b0;
   logic rx_serial_clock = 1'b0;
   logic rxd = 1'b0;
   logic lref = 1'b0;
   logic ext = 1'b0;
   logic p_rx, p_lref, p_ext, er, p_rxd, obs;
   logic [7:0] p_pb;
   sonet_frame_align_pkg::apb_req_t req = '0;
   logic [31:0] rd, prdat;
   logic [7:0] pb, got, x, dout;
   logic [2:0] mck;
   logic [3:0] mon;
   logic tck, tdt, dck, fs, rck, toe, roe, sen, sref, prdy, perr;
   int error_cnt = 0;
   int cmp_count = 0;
   int seed = 42453;
   int n;
   logic bq[$];
   always #2.5 i_clk = ~i_clk;
   assign mon = {fs, dck, rck, mck[0]};
   overhead_partner peer (.i_clk(i_clk), .i_reset_n(rst_n), .i_mux_clk(mck[0]), .o_byte(pb));
   sonet_frame_align_mode_ctrl dut (
      .i_clk(i_clk), .i_reset_n(rst_n), .i_mode_control_pins(pins),
      .i_out_of_frame_in(out_of_frame_in), .i_rx_serial_clock(rx_serial_clock), .i_rx_serial_data(rxd),
      .i_mux_byte_in(pb), .i_low_speed_ref_clock_in(lref),
      .i_ext_high_speed_clock_in(ext), .i_apb_req(req), .o_prdata(prdat),
      .o_pready(prdy), .o_pslverr(perr), .o_tx_serial_clock(tck), .o_tx_serial_data(tdt),
      .o_mux_byte_clock_out(mck), .o_demux_byte_out(dout), .o_demux_byte_clock(dck),
      .o_frame_sync_pulse(fs), .o_demux_ref_clock_out(rck),
      .o_test_chain_observe_out(obs), .o_ttl_oe(toe), .o_ref_clock_oe(roe),
      .o_synth_enable(sen), .o_synth_ref_clock(sref)
   );
   // ****************************************
   // Helpers
   // ****************************************
   task automatic put(input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
         bq.push_back(b[i]);
   endtask : put
   task zeros(input int k);
      repeat (k) bq.push_back(1'b0);
   endtask : zeros
   // Line stream, one bit per cycle, random bytes when idle
   always @(posedge i_clk)
   begin
      p_rx <= rx_serial_clock;
      p_rxd <= rxd;
      p_pb <= pb;
      p_lref <= lref;
      p_ext <= ext;
      {rx_serial_clock, lref, ext} <= 3'($random(seed));
      if (bq.size() == 0)
         put(8'($random(seed)));
      rxd <= bq.pop_front();
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e);
      end
   endtask : chk
   // NAND chain over the test inputs, first element first
   function automatic logic nand_exp(input logic [9:0] t);
      logic c;
      c = 1'b1;
      for (int i = 0; i < 10; i++)
         c = ~(c & t[i]);
      return c;
   endfunction : nand_exp
   task summarize;
      if (error_cnt == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge i_clk);
      req.penable <= 1'b1;
      do
         @(posedge i_clk);
      while (prdy !== 1'b1);
      rd = prdat;
      er = perr;
      req <= '0;
      #1;
   endtask : apb
   task mode(input logic [3:0] m);
      @(posedge i_clk);
      pins <= m;
      repeat (3) @(posedge i_clk);
      #1;
   endtask : mode
   task till(input int s, input logic v, input int lim);
      for (int k = 0; k < lim && mon[s] !== v; k++)
      begin
         @(posedge i_clk);
         #1;
         n++;
      end
   endtask : till
   task per(input int s);
      till(s, 1'b0, 99);
      till(s, 1'b1, 99);
      n = 0;
      till(s, 1'b0, 99);
      till(s, 1'b1, 99);
   endtask : per
   task pulse;
      @(posedge i_clk);
      out_of_frame_in <= 1'b1;
      repeat (2) @(posedge i_clk);
      out_of_frame_in <= 1'b0;
   endtask : pulse
   task frame(input logic [7:0] y);
      for (int i = 0; i < 6; i++)
         put(i < 3 ? 8'hF6 : 8'h28);
      put(y);
      till(3, 1'b1, 200);
      chk(fs, 1'b1);
      chk(dout, 8'h28);
      chk(dck, 1'b0);
      n = 0;
      till(3, 1'b0, 20);
      chk(n, 8);
      chk(dout, y);
   endtask : frame
   // ****************************************
   // Scenarios
   // ****************************************
   initial
   begin
      #300000;
      error_cnt++;
      summarize();
   end
   initial
   begin
      repeat (8) @(posedge i_clk);
      rst_n <= 1'b1;
      apb(1'b0, 8'h04, 32'h0);
      chk(rd[7:0], 8'hF6);
      apb(1'b1, 8'h08, 32'h1);
      chk(er, 1'b1);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h0);
      for (int m = 8; m < 16; m++)
      begin
         mode(m[3:0]);
         apb(1'b0, 8'h04, 32'h0);
         chk(rd[3:1], {~m[2], m[0], m[1]});
         chk(sen, m[2]);
         chk(sref, m[0] ? p_lref : p_rx);
         if (!m[2])
            chk(tck, p_ext);
      end
      per(0);
      chk(n, 8);
      per(1);
      chk(n, 12);
      mode(4'hD);
      per(0);
      chk(n, 32);
      per(1);
      chk(n, 12);
      for (int m = 5; m < 8; m++)
      begin
         mode(m[3:0]);
         apb(1'b0, 8'h04, 32'h0);
         chk(rd[3:1], 3'b010);
         if (m > 5)
         begin
            chk(tck, p_rx);
            chk(tdt, p_rxd);
         end
      end
      mode(4'h1);
      chk({toe, roe}, 2'b01);
      mode(4'h3);
      chk({toe, roe}, 2'b10);
      mode(4'h2);
      repeat (4)
      begin
         chk(obs, nand_exp({p_pb, out_of_frame_in, p_lref}));
         @(posedge i_clk);
         #1;
      end
      mode(4'hF);
      chk(obs, 1'b0);
      repeat (3)
      begin
         till(0, 1'b0, 20);
         till(0, 1'b1, 20);
         x = pb;
         for (int i = 7; i >= 0; i--)
         begin
            got[i] = tdt;
            @(posedge i_clk);
            #1;
         end
         chk(got, x);
      end
      apb(1'b1, 8'h00, 32'h1);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd[0], 1'b1);
      mode(4'h0);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd[10:8], 3'h0);
      chk(rd[0], 1'b0);
      mode(4'h4);
      pulse();
      mode(4'hF);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd[0], 1'b0);
      pulse();
      x = 8'($random(seed)) & 8'h0F;
      put(x);
      zeros(3);
      frame(x);
      zeros(5);
      for (int i = 0; i < 6; i++)
         put(i < 3 ? 8'hF6 : 8'h28);
      till(3, 1'b1, 120);
      chk(fs, 1'b0);
      pulse();
      zeros(3);
      frame(x ^ 8'h05);
      summarize();
   end
endmodule : test_sonet_frame_align_mode_ctrl
